//--- scd_pkg.sv
// shared constants and types for the sdram command decoder
package scd_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W   = 14;
  localparam int BANK_W   = 3;
  localparam int LANE_W   = 8;
  localparam int BEATS    = 8;
  localparam int LAT_W    = 5;

  // ****************************************
  // mode register select and field positions
  // ****************************************
  localparam logic [2:0] MR_ZERO_SEL  = 3'h0;
  localparam logic [2:0] MR_THREE_SEL = 3'h3;
  localparam int MR3_READOUT_BIT = 2;
  localparam int MR3_LOC_LO      = 0;
  localparam int MR0_BL_LO       = 0;
  localparam int AUTOCLOSE_BIT   = 10;
  localparam int CHOP_BIT        = 12;
  localparam int NIBBLE_BIT      = 2;

  // ****************************************
  // burst length codes of mode_reg_zero
  // ****************************************
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // ****************************************
  // readout patterns and reset values
  // ****************************************
  localparam logic [7:0] PATTERN_CAL = 8'haa;
  localparam logic [7:0] PATTERN_RSV = 8'h00;
  localparam logic [1:0] LOC_CAL     = 2'h0;
  localparam logic [1:0] MR0_BL_RST  = 2'h0;

  // ****************************************
  // decoded commands
  // ****************************************
  typedef enum logic [3:0] {
    CMD_DESELECT  = 4'h0,
    CMD_NOP       = 4'h1,
    CMD_MODE_SET  = 4'h2,
    CMD_REFRESH   = 4'h3,
    CMD_SELFREF   = 4'h4,
    CMD_PRECHARGE = 4'h5,
    CMD_CLOSE_ALL = 4'h6,
    CMD_OPEN_ROW  = 4'h7,
    CMD_WRITE     = 4'h8,
    CMD_READ      = 4'h9,
    CMD_ZQ_LONG   = 4'ha,
    CMD_ZQ_SHORT  = 4'hb,
    CMD_POWERDOWN = 4'hc,
    CMD_ILLEGAL   = 4'hd
  } scd_cmd_t;

endpackage : scd_pkg

//--- scd_decode.sv
// combinational command truth-table decoder
`timescale 1ns/1ps
module scd_decode
  import scd_pkg::*;
(
  input  wire logic csN,
  input  wire logic rasN,
  input  wire logic casN,
  input  wire logic weN,
  input  wire logic ckePrev,
  input  wire logic cke,
  input  wire logic autoclose,
  output scd_cmd_t  cmd
);

  // ****************************************
  // truth table
  // ****************************************
  always_comb begin
    cmd = CMD_ILLEGAL;
    if (csN) begin
      cmd = (ckePrev && !cke) ? CMD_POWERDOWN : CMD_DESELECT; // R24
    end else if (ckePrev && !cke) begin
      if (!rasN && !casN && weN) begin
        cmd = CMD_SELFREF; // R24
      end else if (rasN && casN && weN) begin
        cmd = CMD_POWERDOWN; // R24
      end
    end else if (!ckePrev) begin
      cmd = CMD_NOP;
    end else begin
      unique case ({rasN, casN, weN})
        3'b000: cmd = CMD_MODE_SET; // R24
        3'b001: cmd = CMD_REFRESH; // R24
        3'b010: cmd = autoclose ? CMD_CLOSE_ALL : CMD_PRECHARGE; // R22
        3'b011: cmd = CMD_OPEN_ROW; // R22
        3'b100: cmd = CMD_WRITE; // R20
        3'b101: cmd = CMD_READ; // R21
        3'b110: cmd = autoclose ? CMD_ZQ_LONG : CMD_ZQ_SHORT; // R23
        3'b111: cmd = CMD_NOP; // R24
        default: cmd = CMD_ILLEGAL;
      endcase
    end
  end

endmodule : scd_decode

//--- scd_latency.sv
// fixed-depth delay line that holds a read burst request until read latency
`timescale 1ns/1ps
module scd_latency
  import scd_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [LAT_W-1:0] latency,
  input  wire logic             inValid,
  input  wire logic [10:0]      inWord,
  output logic                  outValid,
  output logic [10:0]           outWord
);

  localparam int DEPTH = 1 << LAT_W;

  logic [DEPTH-1:0] validPipe;
  logic [10:0]      wordPipe [DEPTH];

  // same path for pattern and array reads, so latency matches
  always_ff @(posedge mclk) begin
    if (reset) begin
      validPipe <= '0;
    end else begin
      validPipe <= {validPipe[DEPTH-2:0], inValid};
    end
  end

  // head stage picked at elaboration, so no stage ever indexes below zero
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gStage
      if (g == 0) begin : gHead
        always_ff @(posedge mclk) begin
          wordPipe[g] <= inWord;
        end
      end else begin : gBody
        always_ff @(posedge mclk) begin
          wordPipe[g] <= wordPipe[g-1];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (reset) begin
      outValid <= 1'b0;
      outWord  <= '0;
    end else begin
      outValid <= validPipe[latency];
      outWord  <= wordPipe[latency];
    end
  end

endmodule : scd_latency

//--- sdram_command_decode_mpr.sv
// command decoder and pattern readout engine of a ddr sdram
`timescale 1ns/1ps
// What this block and its controller do
// R01 - mode set to mode_reg_three with bit two high enables pattern readout
// R02 - controller idles all banks before enabling pattern readout
// R03 - in readout mode every read returns readout data, not array data
// R04 - controller issues only reads until readout mode is cleared
// R05 - read_with_autoclose acts as a plain read in readout mode
// R06 - controller avoids power-down, self-refresh and other commands in readout mode
// R07 - reset still clears the device while readout mode is on
// R08 - bit two low ignores location bits; accesses go to array
// R09 - four-bit part: lane zero carries data, lanes one to three copy it
// R10 - eight-bit part: lane zero per byte carries data, others copy it
// R11 - controller drives column bits one and zero low on pattern reads
// R12 - eight-beat pattern reads return beats zero through seven
// R13 - chopped reads: address bit two picks low or high nibble
// R14 - bank and other column bits are ignored in pattern reads
// R15 - chop_select_bit picks burst length only when on-the-fly enabled
// R16 - pattern reads keep ordinary read latency and timing
// R17 - controller reads pattern only after delay-locked loop locks
// R18 - beat zero is pattern lsb, beat seven its msb
// R19 - location code zero gives alternating zero-one; others reserved, same order
// R20 - write decode: cs low, ras high, cas low, we low; a10, a12 options
// R21 - read decode: cs low, ras high, cas low, we high; a10, a12 options
// R22 - precharge and open_row decode; a10 selects close_all_banks
// R23 - zq calibration decode; a10 high long, low short
// R24 - mode set, refresh, self-refresh, power-down, nop and deselect decode
// R25 - command pins sampled on every rising clock edge
// R26 - controller enters self-refresh only with all banks idle
module sdram_command_decode_mpr
  import scd_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              csN,
  input  wire logic              rasN,
  input  wire logic              casN,
  input  wire logic              weN,
  input  wire logic              cke,
  input  wire logic [BANK_W-1:0] bank,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              narrowPart,
  input  wire logic              copyLanes,
  input  wire logic [LAT_W-1:0]  readLatency,
  input  wire logic [LANE_W-1:0] arrayData,
  output scd_cmd_t               command,
  output logic                   commandValid,
  output logic                   readoutEnabled,
  output logic [1:0]             readoutLocationCode,
  output logic                   arrayRead,
  output logic                   arrayWrite,
  output logic                   autocloseRequest,
  output logic                   chopRequest,
  output logic [LANE_W-1:0]      dqOut,
  output logic                   dqOutEn
);

  // ****************************************
  // command sampling
  // ****************************************
  logic     ckePrev;
  scd_cmd_t decoded;
  logic     chopThis;
  logic [1:0] mr0Burst;

  scd_decode uDecode (
    .csN       (csN),
    .rasN      (rasN),
    .casN      (casN),
    .weN       (weN),
    .ckePrev   (ckePrev),
    .cke       (cke),
    .autoclose (addr[AUTOCLOSE_BIT]),
    .cmd       (decoded)
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      ckePrev <= 1'b1;
    end else begin
      ckePrev <= cke; // R25
    end
  end

  function automatic logic chop_of(input logic [1:0] bl, input logic a12);
    unique case (bl)
      BL_OTF:    chop_of = !a12;
      BL_FIXED4: chop_of = 1'b1;
      default:   chop_of = 1'b0;
    endcase
  endfunction : chop_of

  assign chopThis = chop_of(mr0Burst, addr[CHOP_BIT]); // R15

  // ****************************************
  // mode registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      readoutEnabled      <= 1'b0; // R07
      readoutLocationCode <= LOC_CAL;
      mr0Burst            <= MR0_BL_RST;
    end else if (decoded == CMD_MODE_SET) begin
      if (bank == MR_THREE_SEL) begin
        readoutEnabled      <= addr[MR3_READOUT_BIT]; // R01
        readoutLocationCode <= addr[MR3_LOC_LO +: 2];
      end else if (bank == MR_ZERO_SEL) begin
        mr0Burst <= addr[MR0_BL_LO +: 2];
      end
    end
  end

  // ****************************************
  // command outputs
  // ****************************************
  logic isRead;
  logic isWrite;
  assign isRead  = decoded == CMD_READ;
  assign isWrite = decoded == CMD_WRITE;

  always_ff @(posedge mclk) begin
    if (reset) begin
      command          <= CMD_DESELECT;
      commandValid     <= 1'b0;
      arrayRead        <= 1'b0;
      arrayWrite       <= 1'b0;
      autocloseRequest <= 1'b0;
      chopRequest      <= 1'b0;
    end else begin
      command      <= decoded; // R25
      commandValid <= decoded != CMD_DESELECT && decoded != CMD_NOP;
      arrayRead    <= isRead && !readoutEnabled; // R03 R08
      arrayWrite   <= isWrite && !readoutEnabled; // R08
      // no auto close in readout mode
      autocloseRequest <= (isRead || isWrite) && addr[AUTOCLOSE_BIT]
                          && !readoutEnabled; // R05 R20 R21
      chopRequest  <= (isRead || isWrite) && chopThis; // R20 R21
    end
  end

  // ****************************************
  // read burst launch, through shared latency line
  // ****************************************
  logic        launchValid;
  logic [10:0] launchWord;
  logic        burstValid;
  logic [10:0] burstWord;

  // word: pattern(8) readout(1) chop(1) nibble(1); bank and other bits unused
  assign launchValid = isRead; // R03 R05
  assign launchWord  = {(readoutLocationCode == LOC_CAL) ? PATTERN_CAL : PATTERN_RSV,
                        readoutEnabled, chopThis, addr[NIBBLE_BIT]}; // R14 R19

  scd_latency uLatency (
    .mclk     (mclk),
    .reset    (reset),
    .latency  (readLatency),
    .inValid  (launchValid),
    .inWord   (launchWord),
    .outValid (burstValid),
    .outWord  (burstWord)
  ); // R16

  // ****************************************
  // beat serialiser
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_BURST = 2'b10
  } scd_state_t;

  scd_state_t  state;
  logic [2:0]  beat;
  logic [2:0]  lastBeat;
  logic [7:0]  pattern;
  logic        fromReadout;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state       <= ST_IDLE;
      beat        <= 3'h0;
      lastBeat    <= 3'h0;
      pattern     <= 8'h00;
      fromReadout <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (burstValid) begin
            state       <= ST_BURST;
            pattern     <= burstWord[10:3];
            fromReadout <= burstWord[2];
            // chop: nibble bit picks beats 4..7 else 0..3
            beat        <= (burstWord[1] && burstWord[0]) ? 3'h4 : 3'h0; // R13 R12
            lastBeat    <= burstWord[1] ? (burstWord[0] ? 3'h7 : 3'h3) : 3'h7;
          end
        end
        ST_BURST: begin
          if (beat == lastBeat) begin
            state <= ST_IDLE;
          end else begin
            beat <= beat + 3'h1; // R12
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // lane drive
  // ****************************************
  logic bitNow;
  assign bitNow = pattern[beat]; // R18

  always_ff @(posedge mclk) begin
    if (reset) begin
      dqOut   <= '0;
      dqOutEn <= 1'b0;
    end else begin
      dqOutEn <= state == ST_BURST;
      if (state != ST_BURST) begin
        dqOut <= '0;
      end else if (!fromReadout) begin
        dqOut <= arrayData;
      end else begin
        dqOut    <= {LANE_W{copyLanes & bitNow}}; // R09 R10
        dqOut[0] <= bitNow; // R09 R10
        if (narrowPart) begin
          dqOut[LANE_W-1:4] <= '0; // R09
        end
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence readoutSet_s;
    decoded == CMD_MODE_SET && bank == MR_THREE_SEL && addr[MR3_READOUT_BIT];
  endsequence

  sequence readoutClear_s;
    decoded == CMD_MODE_SET && bank == MR_THREE_SEL && !addr[MR3_READOUT_BIT];
  endsequence

  sequence readInReadout_s;
    isRead && readoutEnabled;
  endsequence

  // a delayed request only starts a burst when the serialiser is free
  sequence fullStart_s;
    state == ST_IDLE && burstValid && !burstWord[1];
  endsequence

  sequence chopStart_s;
    state == ST_IDLE && burstValid && burstWord[1];
  endsequence

  sequence fullBurst_s;
    (state == ST_BURST) [*8] ##1 (state == ST_IDLE);
  endsequence

  sequence chopBurst_s;
    (state == ST_BURST) [*4] ##1 (state == ST_IDLE);
  endsequence

  readout_enable_a: assert property (@(posedge mclk) disable iff (reset) // R01
    readoutSet_s |=> readoutEnabled) else $error("readout not enabled");
  readout_clear_a: assert property (@(posedge mclk) disable iff (reset) // R08
    readoutClear_s |=> !readoutEnabled) else $error("readout not cleared");
  readout_no_array_a: assert property (@(posedge mclk) disable iff (reset) // R03
    readInReadout_s |=> !arrayRead) else $error("array read in readout");
  readout_no_close_a: assert property (@(posedge mclk) disable iff (reset) // R05
    readInReadout_s |=> !autocloseRequest) else $error("autoclose in readout");
  array_close_a: assert property (@(posedge mclk) disable iff (reset) // R21
    isRead && !readoutEnabled && addr[AUTOCLOSE_BIT] |=> autocloseRequest)
    else $error("autoclose lost on array read");
  reset_clears_a: assert property (@(posedge mclk) // R07
    reset |=> !readoutEnabled && !dqOutEn) else $error("reset ignored");
  lane_zero_a: assert property (@(posedge mclk) disable iff (reset) // R09 R10
    state == ST_BURST && fromReadout |=> dqOut[0] == $past(bitNow))
    else $error("lane zero wrong");
  narrow_lanes_a: assert property (@(posedge mclk) disable iff (reset) // R09
    state == ST_BURST && fromReadout && narrowPart |=> dqOut[LANE_W-1:4] == '0)
    else $error("upper lanes driven on narrow part");
  zero_lanes_a: assert property (@(posedge mclk) disable iff (reset) // R10
    state == ST_BURST && fromReadout && !copyLanes |=> dqOut[LANE_W-1:1] == '0)
    else $error("lanes not zero without copy");
  beat_order_a: assert property (@(posedge mclk) disable iff (reset) // R12
    state == ST_BURST && beat != lastBeat |=> beat == $past(beat) + 3'h1)
    else $error("beat order broken");
  full_burst_a: assert property (@(posedge mclk) disable iff (reset) // R12
    fullStart_s |=> fullBurst_s) else $error("full burst length wrong");
  chop_burst_a: assert property (@(posedge mclk) disable iff (reset) // R13
    chopStart_s |=> chopBurst_s) else $error("chopped burst length wrong");
  chop_high_a: assert property (@(posedge mclk) disable iff (reset) // R13
    state == ST_IDLE && burstValid && burstWord[1] && burstWord[0] |=> beat == 3'h4)
    else $error("nibble select wrong");
  write_decode_a: assert property (@(posedge mclk) disable iff (reset) // R20
    !csN && rasN && !casN && !weN && cke && ckePrev |=> command == CMD_WRITE)
    else $error("write misdecoded");
  precharge_decode_a: assert property (@(posedge mclk) disable iff (reset) // R22
    !csN && !rasN && casN && !weN && cke && ckePrev && !addr[AUTOCLOSE_BIT]
    |=> command == CMD_PRECHARGE) else $error("precharge misdecoded");
  open_row_decode_a: assert property (@(posedge mclk) disable iff (reset) // R22
    !csN && !rasN && casN && weN && cke && ckePrev |=> command == CMD_OPEN_ROW)
    else $error("open row misdecoded");
  zq_decode_a: assert property (@(posedge mclk) disable iff (reset) // R23
    !csN && rasN && casN && !weN && cke && ckePrev && addr[AUTOCLOSE_BIT]
    |=> command == CMD_ZQ_LONG) else $error("zq misdecoded");
  selfref_decode_a: assert property (@(posedge mclk) disable iff (reset) // R24
    !csN && !rasN && !casN && weN && ckePrev && !cke |=> command == CMD_SELFREF)
    else $error("self refresh misdecoded");

endmodule : sdram_command_decode_mpr

//--- scd_ctrl_model.sv
// controller-side model that drives the command and address pins
`timescale 1ns/1ps
module scd_ctrl_model
  import scd_pkg::*;
(
  input  wire logic              mclk,
  output logic                   csN,
  output logic                   rasN,
  output logic                   casN,
  output logic                   weN,
  output logic                   cke,
  output logic [BANK_W-1:0]      bank,
  output logic [ADDR_W-1:0]      addr
);
  // ****************************************
  // command issue
  // ****************************************
  // dll taken as locked from reset release, so reads may follow at once
  initial begin
    {csN, rasN, casN, weN, cke} = 5'h1f;
    bank = 3'h0;
    addr = 14'h0000;
  end

  // pins move after a falling edge and hold across the sampling edge
  task automatic send(input logic [3:0] p, input logic k, input logic [2:0] b,
                      input logic [13:0] a);
    @(negedge mclk);
    {csN, rasN, casN, weN} <= p;
    cke  <= k;
    bank <= b;
    addr <= a;
    @(negedge mclk);
    {csN, rasN, casN, weN} <= 4'h7;
    cke  <= 1'b1;
    bank <= ~b;
    // address no longer qualified: show the inverse, not a stale copy
    addr <= ~a;
  endtask : send
endmodule : scd_ctrl_model

//--- sdram_command_decode_mpr_test.sv
// self-checking bench for the command decoder and pattern readout
`timescale 1ns/1ps
module sdram_command_decode_mpr_test;
  import scd_pkg::*;
  logic              mclk;
  logic              reset;
  logic              csN;
  logic              rasN;
  logic              casN;
  logic              weN;
  logic              cke;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic              narrowPart;
  logic              copyLanes;
  logic [LAT_W-1:0]  readLatency;
  logic [LANE_W-1:0] arrayData;
  scd_cmd_t          command;
  logic              commandValid;
  logic              readoutEnabled;
  logic [1:0]        readoutLocationCode;
  logic              arrayRead;
  logic              arrayWrite;
  logic              autocloseRequest;
  logic              chopRequest;
  logic [LANE_W-1:0] dqOut;
  logic              dqOutEn;
  wire logic [4:0]   flags;
  int                n_fail;
  int                n_compared;
  int                cyc;
  int                la;
  int                lm;
  int                c;

  assign flags = {commandValid, arrayRead, arrayWrite, autocloseRequest, chopRequest};

  sdram_command_decode_mpr dut (
    .mclk, .reset, .csN, .rasN, .casN, .weN, .cke, .bank, .addr, .narrowPart,
    .copyLanes, .readLatency, .arrayData, .command, .commandValid, .readoutEnabled,
    .readoutLocationCode, .arrayRead, .arrayWrite, .autocloseRequest, .chopRequest,
    .dqOut, .dqOutEn
  );

  scd_ctrl_model ctrl (
    .mclk, .csN, .rasN, .casN, .weN, .cke, .bank, .addr
  );

  // ****************************************
  // clock, timeout and report
  // ****************************************
  always #12.5 mclk = ~mclk;

  // whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // ****************************************
  // access tasks
  // ****************************************
  // command and flags stand for one cycle after the sampling edge
  task automatic cmdChk(input logic [3:0] p, input logic k, input logic [2:0] b,
                        input logic [13:0] a, input scd_cmd_t e, input logic [4:0] f);
    logic       hit;
    logic [4:0] seen;
    ctrl.send(p, k, b, a);
    hit  = command === e;
    seen = flags;
    @(negedge mclk);
    seen |= flags;
    @(negedge mclk);
    cmp(8'(hit), 8'h01);
    cmp(8'(seen), 8'(f));
  endtask : cmdChk

  task automatic rd(input logic [13:0] a, input int s, input int nb, input logic [7:0] pat,
                    input logic [7:0] lanes, input logic [4:0] f, output int lat);
    logic [4:0] seen;
    int         i;
    seen = 5'h00;
    ctrl.send(4'h5, 1'b1, 3'h7, a);
    lat = 1;
    while (dqOutEn !== 1'b1 && lat < 40) begin
      seen |= flags;
      @(negedge mclk);
      lat++;
    end
    cmp(8'(seen), 8'(f));
    for (i = 0; i < nb; i++) begin
      cmp(dqOut, pat[s + i] ? lanes : 8'h00);
      @(negedge mclk);
    end
    cmp(8'(dqOutEn), 8'h00);
  endtask : rd

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    narrowPart = 1'b0;
    copyLanes = 1'b1;
    readLatency = 5'h05;
    arrayData = 8'h5c;
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    cmdChk(4'h0, 1'b1, 3'h0, 14'h0000, CMD_MODE_SET, 5'h10);
    cmdChk(4'h1, 1'b1, 3'h0, 14'h0000, CMD_REFRESH, 5'h10);
    cmdChk(4'h3, 1'b1, 3'h1, 14'h0000, CMD_OPEN_ROW, 5'h10);
    cmdChk(4'h4, 1'b1, 3'h1, 14'h1400, CMD_WRITE, 5'h16);
    rd(14'h1400, 0, 8, 8'hff, 8'h5c, 5'h1a, la);
    cmdChk(4'h2, 1'b1, 3'h1, 14'h0000, CMD_PRECHARGE, 5'h10);
    cmdChk(4'h6, 1'b1, 3'h0, 14'h0400, CMD_ZQ_LONG, 5'h10);
    cmdChk(4'h6, 1'b1, 3'h0, 14'h0000, CMD_ZQ_SHORT, 5'h10);
    cmdChk(4'h7, 1'b1, 3'h0, 14'h0000, CMD_NOP, 5'h00);
    cmdChk(4'h8, 1'b1, 3'h0, 14'h0000, CMD_DESELECT, 5'h00);
    cmdChk(4'h7, 1'b0, 3'h0, 14'h0000, CMD_POWERDOWN, 5'h10);
    cmdChk(4'h1, 1'b0, 3'h0, 14'h0000, CMD_SELFREF, 5'h10);
    cmdChk(4'h4, 1'b0, 3'h0, 14'h0000, CMD_ILLEGAL, 5'h10);
    cmdChk(4'h0, 1'b1, 3'h0, 14'h0001, CMD_MODE_SET, 5'h10);
    cmdChk(4'h4, 1'b1, 3'h0, 14'h0000, CMD_WRITE, 5'h15);
    rd(14'h0000, 0, 4, 8'hff, 8'h5c, 5'h19, lm);
    cmdChk(4'h2, 1'b1, 3'h0, 14'h0400, CMD_CLOSE_ALL, 5'h10);
    cmdChk(4'h0, 1'b1, 3'h3, 14'h0004, CMD_MODE_SET, 5'h10);
    cmp(8'(readoutEnabled), 8'h01);
    // only reads from here until readout is switched off
    rd(14'h3ff8, 0, 8, PATTERN_CAL, 8'hff, 5'h10, lm);
    cmp(8'(lm), 8'(la));
    copyLanes = 1'b0;
    rd(14'h0004, 4, 4, PATTERN_CAL, 8'h01, 5'h11, lm);
    narrowPart = 1'b1;
    copyLanes = 1'b1;
    rd(14'h0000, 0, 4, PATTERN_CAL, 8'h0f, 5'h11, lm);
    narrowPart = 1'b0;
    // leave readout mode before picking a new location: only reads inside it
    for (c = 1; c < 4; c++) begin
      cmdChk(4'h0, 1'b1, 3'h3, 14'h0000, CMD_MODE_SET, 5'h10);
      cmdChk(4'h0, 1'b1, 3'h3, 14'(4 + c), CMD_MODE_SET, 5'h10);
      cmp(8'(readoutLocationCode), 8'(c));
      rd(14'h1000, 0, 8, PATTERN_RSV, 8'hff, 5'h10, lm);
    end
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    cmp(8'({readoutEnabled, readoutLocationCode}), 8'h00);
    cmdChk(4'h0, 1'b1, 3'h3, 14'h0004, CMD_MODE_SET, 5'h10);
    cmdChk(4'h0, 1'b1, 3'h3, 14'h0003, CMD_MODE_SET, 5'h10);
    cmp(8'(readoutEnabled), 8'h00);
    rd(14'h0000, 0, 8, 8'hff, 8'h5c, 5'h18, lm);
    // fixed chop code: chop_select_bit high must not lengthen the burst
    cmdChk(4'h0, 1'b1, 3'h0, 14'h0002, CMD_MODE_SET, 5'h10);
    rd(14'h1000, 0, 4, 8'hff, 8'h5c, 5'h19, lm);
    report_and_stop();
  end
endmodule : sdram_command_decode_mpr_test
